// ==== src/i2cr_defines.svh ====
// Purpose: named constants of the two-wire control register block
// Assumes: 8-bit byte addresses on the register bus, 32-bit data
// Notes:   the package holds the types, this header the numbers
//
// Contract
// - enable bit 6 turns the module on; disabled means no bus action.
// - start request bit 5 starts at once if idle, else after stop.
// - start request while master with bytes sent gives repeated start.
// - start request may be set anytime; hardware never clears it.
// - writing 0 clears start request, writing 1 requests a start.
// - stop request bit 4 write 1 sends stop, cleared when done; 0 ignored.
// - master with both requests set sends stop then start at once.
// - bus error status 00H sets stop request without driving a stop.
// - flag bit 3 set on every defined state except F8H.
// - only a software 0 write clears the flag, advancing the engine.
// - clock line held low while the flag is set.
// - ack enable bit 2 picks ACK when 1, NACK when 0.
// - slave missing an ACK drops to unaddressed until AA and readdressed.
// - slave with AA cleared before last byte detaches; reads give 0xFF.
// - filter select bit 0: 0 advanced filtering, 1 simple filtering.
// - status F8H leaves the flag 0; other codes set it.
// - clock tick rate is clock divided by 8 then divider plus one.
`ifndef I2CR_DEFINES_SVH
`define I2CR_DEFINES_SVH

// ==========================================
// register map
`define I2CR_OFF_DIV   8'h04
`define I2CR_OFF_CTL   8'h08
`define I2CR_OFF_STAT  8'h14
`define I2CR_RESP_OK   2'h0
`define I2CR_RESP_ERR  2'h2

// ==========================================
// control fields and reset values
`define I2CR_EN        6
`define I2CR_STA       5
`define I2CR_STO       4
`define I2CR_SI        3
`define I2CR_AA        2
`define I2CR_FLT       0
`define I2CR_CTL_MASK  8'h7D
`define I2CR_STAT_RST  8'hF8

// ==========================================
// status codes and timing
`define I2CR_ST_NONE   8'hF8
`define I2CR_ST_BUSERR 8'h00
`define I2CR_IDLE_BYTE 8'hFF
`define I2CR_PRE_LAST  3'h7
`define I2CR_FLT_ADV   3'h3
`define I2CR_FLT_SMP   3'h1
`define I2CR_LINE_IDLE 2'h3

`endif

// ==== src/i2cr_pkg.sv ====
// Purpose: types shared by the control register block
// Assumes: nothing beyond the defines header
// Notes:   one-hot codes for the condition generator
package i2cr_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_WAIT  = 4'h2,
        ST_START = 4'h4,
        ST_STOP  = 4'h8
    } i2cr_gen_t;

    typedef struct packed {
        logic [1:0][2:0] cnt;
        logic [1:0]      filt;
    } i2cr_flt_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_hold;
        logic        w_hold;
        logic [7:0]  aw_addr;
        logic [7:0]  w_data;
        logic        w_lane0;
        logic [1:0]  sy1;
        logic [1:0]  sy2;
        logic [1:0]  lines_d;
        logic [7:0]  ctl;
        logic [7:0]  div;
        logic [7:0]  status;
        i2cr_gen_t   gen;
        logic        busy;
        logic        master;
        logic        sta_done;
        logic        bus_err;
        logic        addressed;
        logic        detached;
        logic [2:0]  pre;
        logic [7:0]  cnt;
        logic        tick;
        logic        cmd_start;
        logic        cmd_rstart;
        logic        cmd_stop;
        logic        advance;
        logic        scl_oe;
        logic        ack_reply;
    } i2cr_st_t;

endpackage

// ==== src/i2cr_glitch.sv ====
// Purpose: glitch filter on the synchronised clock and data lines
// Assumes: inputs already pass two flip-flops
// Notes:   a level must persist lim+1 samples before it is accepted
`timescale 1ns/1ps
`default_nettype none
`include "i2cr_defines.svh"

module i2cr_glitch (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       simple,
    input  wire logic [1:0] line_in,
    output var  logic [1:0] line_out
);
    import i2cr_pkg::*;

    i2cr_flt_t  f_r;
    i2cr_flt_t  f_nxt;
    logic [2:0] lim;

    always_comb begin
        f_nxt = f_r;
        // longer run for stronger rejection, shorter for faster edges
        lim = simple ? `I2CR_FLT_SMP : `I2CR_FLT_ADV;
        for (int i = 0; i < 2; i++) begin
            if (line_in[i] == f_r.filt[i]) begin
                f_nxt.cnt[i] = 3'h0;
            end else if (f_r.cnt[i] == lim) begin
                f_nxt.filt[i] = line_in[i];
                f_nxt.cnt[i] = 3'h0;
            end else begin
                f_nxt.cnt[i] = 3'(f_r.cnt[i] + 3'h1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            f_r <= '0;
            f_r.filt <= `I2CR_LINE_IDLE;
        end else begin
            f_r <= f_nxt;
        end
    end

    assign line_out = f_r.filt;

endmodule // i2cr_glitch
`default_nettype wire

// ==== src/i2cr_ctrl.sv ====
// Purpose: control register, condition requests and flag of a two-wire port
// Assumes: protocol engine on sys_clk reports status codes and slave events
// Notes:   divider, status and control registers on an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "i2cr_defines.svh"

module i2cr_ctrl (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output var  logic        scl_out,
    output var  logic        scl_oe,
    input  wire logic        eng_stat_valid,
    input  wire logic [7:0]  eng_stat,
    input  wire logic        eng_byte_done,
    input  wire logic        eng_nack,
    input  wire logic        eng_addr_match,
    output var  logic        cmd_start,
    output var  logic        cmd_rstart,
    output var  logic        cmd_stop,
    output var  logic        state_advance,
    output var  logic        scl_tick,
    output var  logic        ack_reply,
    output var  logic        slave_sel,
    output var  logic        tx_idle_byte,
    output var  logic        master_mode
);
    import i2cr_pkg::*;

    // ==========================================
    // state and decode
    i2cr_st_t   s_r;
    i2cr_st_t   s_nxt;
    logic [1:0] lf;
    logic [2:0] wsel;
    logic [2:0] rsel;
    logic       do_wr;
    logic       wr_ctl;
    logic       start_seen;
    logic       stop_seen;
    logic       en;
    logic       si;
    logic       pend;

    function automatic logic [2:0] reg_sel(input logic [7:0] a);
        reg_sel = {a == `I2CR_OFF_STAT, a == `I2CR_OFF_CTL, a == `I2CR_OFF_DIV};
    endfunction

    i2cr_glitch u_flt (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .simple   (s_r.ctl[`I2CR_FLT]),
        .line_in  (s_r.sy2),
        .line_out (lf)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        s_nxt.cmd_start = 1'b0;
        s_nxt.cmd_rstart = 1'b0;
        s_nxt.cmd_stop = 1'b0;
        s_nxt.advance = 1'b0;
        en = s_r.ctl[`I2CR_EN];
        si = s_r.ctl[`I2CR_SI];
        pend = s_r.ctl[`I2CR_STA] & ~s_r.sta_done;

        // ==========================================
        // line watch: start and stop seen on the filtered lines
        s_nxt.sy1 = {scl_in, sda_in};
        s_nxt.sy2 = s_r.sy1;
        s_nxt.lines_d = lf;
        start_seen = lf[1] & s_r.lines_d[1] & s_r.lines_d[0] & ~lf[0];
        stop_seen = lf[1] & s_r.lines_d[1] & ~s_r.lines_d[0] & lf[0];
        if (start_seen) begin
            s_nxt.busy = 1'b1;
        end
        if (stop_seen) begin
            s_nxt.busy = 1'b0;
            s_nxt.master = 1'b0;
        end

        // ==========================================
        // bus slave: address and data taken in either order
        wsel = reg_sel(s_r.aw_addr);
        rsel = reg_sel(s_axi_araddr);
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_hold = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_hold = 1'b1;
            s_nxt.w_data = s_axi_wdata[7:0];
            s_nxt.w_lane0 = s_axi_wstrb[0];
        end
        do_wr = s_r.aw_hold & s_r.w_hold & ~s_r.bvalid;
        wr_ctl = do_wr & s_r.w_lane0 & wsel[1];
        if (do_wr) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = (|wsel) ? `I2CR_RESP_OK : `I2CR_RESP_ERR;
            s_nxt.aw_hold = 1'b0;
            s_nxt.w_hold = 1'b0;
            if (s_r.w_lane0 && wsel[0]) begin
                s_nxt.div = s_r.w_data;
            end
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        s_nxt.awready = ~s_nxt.aw_hold & ~s_nxt.bvalid;
        s_nxt.wready = ~s_nxt.w_hold & ~s_nxt.bvalid;
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = (|rsel) ? `I2CR_RESP_OK : `I2CR_RESP_ERR;
            case (1'b1)
                rsel[0]: s_nxt.rdata = {24'h0, s_r.div};
                rsel[1]: s_nxt.rdata = {24'h0, s_r.ctl & `I2CR_CTL_MASK};
                rsel[2]: s_nxt.rdata = {24'h0, s_r.status};
                default: s_nxt.rdata = 32'h0;
            endcase
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        s_nxt.arready = ~s_nxt.rvalid;

        // ==========================================
        // condition generator; in idle it waits while the flag stretches the clock
        case (s_r.gen)
            ST_IDLE: begin
                if (en && !si) begin
                    if (s_r.ctl[`I2CR_STO] && !s_r.bus_err) begin
                        if (s_r.master) begin
                            s_nxt.cmd_stop = 1'b1;
                            s_nxt.gen = ST_STOP;
                        end else begin
                            // a slave only releases, it never frames a stop
                            s_nxt.ctl[`I2CR_STO] = 1'b0;
                            s_nxt.addressed = 1'b0;
                        end
                    end else if (pend) begin
                        if (s_r.master) begin
                            s_nxt.cmd_rstart = 1'b1;
                            s_nxt.gen = ST_START;
                        end else if (!s_r.busy) begin
                            s_nxt.cmd_start = 1'b1;
                            s_nxt.gen = ST_START;
                        end else begin
                            s_nxt.gen = ST_WAIT;
                        end
                    end
                end
            end
            ST_WAIT: begin
                if (!pend) begin
                    s_nxt.gen = ST_IDLE;
                end else if (!s_r.busy) begin
                    s_nxt.cmd_start = 1'b1;
                    s_nxt.gen = ST_START;
                end
            end
            ST_START: begin
                if (start_seen) begin
                    // request bit stays; only this attempt is spent
                    s_nxt.sta_done = 1'b1;
                    s_nxt.master = 1'b1;
                    s_nxt.gen = ST_IDLE;
                end
            end
            ST_STOP: begin
                if (stop_seen) begin
                    s_nxt.ctl[`I2CR_STO] = 1'b0;
                    if (s_r.ctl[`I2CR_STA]) begin
                        s_nxt.cmd_start = 1'b1;
                        s_nxt.gen = ST_START;
                    end else begin
                        s_nxt.gen = ST_IDLE;
                    end
                end
            end
            default: s_nxt.gen = ST_IDLE;
        endcase
        if (!en) begin
            s_nxt.gen = ST_IDLE;
            s_nxt.master = 1'b0;
            s_nxt.cmd_start = 1'b0;
            s_nxt.cmd_rstart = 1'b0;
            s_nxt.cmd_stop = 1'b0;
        end

        // ==========================================
        // control register write; hardware sets below win over it
        if (wr_ctl) begin
            s_nxt.ctl[`I2CR_EN] = s_r.w_data[`I2CR_EN];
            s_nxt.ctl[`I2CR_STA] = s_r.w_data[`I2CR_STA];
            s_nxt.ctl[`I2CR_AA] = s_r.w_data[`I2CR_AA];
            s_nxt.ctl[`I2CR_FLT] = s_r.w_data[`I2CR_FLT];
            if (!s_r.w_data[`I2CR_STA]) begin
                s_nxt.sta_done = 1'b0;
            end
            if (!s_r.w_data[`I2CR_SI] && si) begin
                s_nxt.ctl[`I2CR_SI] = 1'b0;
                s_nxt.advance = 1'b1;
                s_nxt.sta_done = 1'b0;
                if (s_r.bus_err) begin
                    s_nxt.ctl[`I2CR_STO] = 1'b0;
                    s_nxt.bus_err = 1'b0;
                end
            end
            if (s_r.w_data[`I2CR_STO]) begin
                s_nxt.ctl[`I2CR_STO] = 1'b1;
            end
        end

        // ==========================================
        // slave tracking and engine events
        if (eng_nack && s_r.addressed) begin
            s_nxt.addressed = 1'b0;
        end
        if (eng_byte_done && s_r.addressed && !s_r.master && !s_r.ctl[`I2CR_AA]) begin
            s_nxt.addressed = 1'b0;
            s_nxt.detached = 1'b1;
        end
        if (start_seen || stop_seen) begin
            s_nxt.detached = 1'b0;
        end
        if (eng_addr_match && s_r.ctl[`I2CR_AA] && !s_r.master) begin
            s_nxt.addressed = 1'b1;
            s_nxt.detached = 1'b0;
        end
        if (eng_stat_valid) begin
            s_nxt.status = eng_stat;
            if (eng_stat != `I2CR_ST_NONE) begin
                s_nxt.ctl[`I2CR_SI] = 1'b1;
            end
            if (eng_stat == `I2CR_ST_BUSERR) begin
                s_nxt.ctl[`I2CR_STO] = 1'b1;
                s_nxt.bus_err = 1'b1;
            end
        end
        s_nxt.scl_oe = s_nxt.ctl[`I2CR_EN] & s_nxt.ctl[`I2CR_SI];
        s_nxt.ack_reply = s_nxt.ctl[`I2CR_EN] & s_nxt.ctl[`I2CR_AA] & ~s_nxt.detached;

        // ==========================================
        // clock tick: divide by 8, then by divider plus one; 0 halts it
        if (en && s_r.div != 8'h00) begin
            s_nxt.pre = 3'(s_r.pre + 3'h1);
            if (s_r.pre == `I2CR_PRE_LAST) begin
                if (s_r.cnt == s_r.div) begin
                    s_nxt.cnt = 8'h00;
                    s_nxt.tick = 1'b1;
                end else begin
                    s_nxt.cnt = 8'(s_r.cnt + 8'h01);
                end
            end
        end else begin
            s_nxt.pre = 3'h0;
            s_nxt.cnt = 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_r <= '0;
            s_r.status <= `I2CR_STAT_RST;
            s_r.gen <= ST_IDLE;
            s_r.sy1 <= `I2CR_LINE_IDLE;
            s_r.sy2 <= `I2CR_LINE_IDLE;
            s_r.lines_d <= `I2CR_LINE_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================
    // outputs
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign scl_out = 1'b0;
    assign scl_oe = s_r.scl_oe;
    assign cmd_start = s_r.cmd_start;
    assign cmd_rstart = s_r.cmd_rstart;
    assign cmd_stop = s_r.cmd_stop;
    assign state_advance = s_r.advance;
    assign scl_tick = s_r.tick;
    assign ack_reply = s_r.ack_reply;
    assign slave_sel = s_r.addressed;
    assign tx_idle_byte = s_r.detached;
    assign master_mode = s_r.master;

    // ==========================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_ready;
        s_r.gen == ST_IDLE && en && !si && !s_r.ctl[`I2CR_STO];
    endsequence
    sequence s_stop_done;
        s_r.gen == ST_STOP && stop_seen && en && !wr_ctl;
    endsequence

    property p_dis;
        !en |=> !(s_r.cmd_start || s_r.cmd_rstart || s_r.cmd_stop);
    endproperty
    a_dis: assert property (p_dis)
        else $error("command issued while disabled");
    property p_start_now;
        s_ready ##0 (pend && !s_r.master && !s_r.busy) |=> s_r.cmd_start ##1 s_r.gen == ST_START;
    endproperty
    a_start_now: assert property (p_start_now)
        else $error("start not issued on idle bus");
    property p_rstart;
        s_ready ##0 (pend && s_r.master) |=> s_r.cmd_rstart && !s_r.cmd_start;
    endproperty
    a_rstart: assert property (p_rstart)
        else $error("repeated start not issued");
    property p_sta_kept;
        s_r.ctl[`I2CR_STA] && !wr_ctl |=> s_r.ctl[`I2CR_STA];
    endproperty
    a_sta_kept: assert property (p_sta_kept)
        else $error("start request cleared by hardware");
    property p_sta_clr;
        wr_ctl && !s_r.w_data[`I2CR_STA] |=> !s_r.ctl[`I2CR_STA];
    endproperty
    a_sta_clr: assert property (p_sta_clr)
        else $error("start request not cleared by write");
    property p_stop_start;
        s_stop_done ##0 s_r.ctl[`I2CR_STA] |=> s_r.cmd_start && !s_r.ctl[`I2CR_STO];
    endproperty
    a_stop_start: assert property (p_stop_start)
        else $error("stop then start sequence broken");
    property p_buserr;
        eng_stat_valid && eng_stat == `I2CR_ST_BUSERR |=> s_r.ctl[`I2CR_STO] ##1 !s_r.cmd_stop;
    endproperty
    a_buserr: assert property (p_buserr)
        else $error("bus error handling wrong");
    property p_si_set;
        eng_stat_valid && eng_stat != `I2CR_ST_NONE |=> si;
    endproperty
    a_si_set: assert property (p_si_set)
        else $error("flag not set on status");
    property p_si_none;
        eng_stat_valid && eng_stat == `I2CR_ST_NONE && !si |=> !si;
    endproperty
    a_si_none: assert property (p_si_none)
        else $error("flag set on no-information status");
    property p_si_clr;
        si && wr_ctl && !s_r.w_data[`I2CR_SI] && !eng_stat_valid |=> !si && s_r.advance;
    endproperty
    a_si_clr: assert property (p_si_clr)
        else $error("flag clear did not advance");
    property p_stretch;
        si && en |-> s_r.scl_oe;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("clock not held low under flag");
    property p_tick;
        s_r.tick |=> !s_r.tick [*8];
    endproperty
    a_tick: assert property (p_tick)
        else $error("clock tick too frequent");

endmodule // i2cr_ctrl
`default_nettype wire

// ==== testbench/i2cr_partner.sv ====
// Purpose: far-side bus party that frames conditions on the lines
// Assumes: pulled-up lines that idle high
// Notes:   no arbitration and no data bits, only START and STOP
`timescale 1ns/1ps
`default_nettype none
module i2cr_partner (
    input  wire logic sys_clk,
    input  wire logic cmd_start,
    input  wire logic cmd_rstart,
    input  wire logic cmd_stop,
    output var  logic scl_line,
    output var  logic sda_line
);
    initial begin
        scl_line = 1'b1;
        sda_line = 1'b1;
    end
    // ==========================================
    // condition framing, slow on purpose
    always @(posedge sys_clk) begin
        if (cmd_start || cmd_rstart) begin
            sda_line <= 1'b1;
            repeat (3) @(posedge sys_clk);
            scl_line <= 1'b1;
            repeat (6) @(posedge sys_clk);
            sda_line <= 1'b0;
            repeat (6) @(posedge sys_clk);
            scl_line <= 1'b0;
        end else if (cmd_stop) begin
            sda_line <= 1'b0;
            repeat (6) @(posedge sys_clk);
            scl_line <= 1'b1;
            repeat (6) @(posedge sys_clk);
            sda_line <= 1'b1;
        end
    end
endmodule // i2cr_partner
`default_nettype wire

// ==== testbench/tb_i2c_control_register_logic.sv ====
// Purpose: register-level test of the two-wire control block
// Assumes: engine events driven by the bench
// Notes:   software never sets both requests in slave mode
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_control_register_logic;
    logic sys_clk = 1'b0, srst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, estat = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, esv = 0;
    logic awr, wr_, bv, arr, rv, scl_oe, scl_out, scl_l, sda_l;
    logic c_st, c_rs, c_sp, adv, ack, mst, tk, ssel, tidle;
    logic [2:0] epl = 3'h0;
    logic [1:0] bresp, rresp;
    int n_mismatch = 0, compares = 0, cyc = 0, n_st = 0, n_rs = 0, n_sp = 0, n_adv = 0, n_tk = 0, i;
    logic [31:0] v;
    logic [1:0] rs;
    always #25 sys_clk = ~sys_clk;
    wire scl_w = scl_l & ~(scl_oe & ~scl_out);
    i2cr_ctrl DUT (.sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .scl_in(scl_w), .sda_in(sda_l),
        .scl_out(scl_out), .scl_oe(scl_oe), .eng_stat_valid(esv), .eng_stat(estat),
        .eng_byte_done(epl[0]), .eng_nack(epl[1]), .eng_addr_match(epl[2]), .cmd_start(c_st),
        .cmd_rstart(c_rs), .cmd_stop(c_sp), .state_advance(adv), .scl_tick(tk), .ack_reply(ack),
        .slave_sel(ssel), .tx_idle_byte(tidle), .master_mode(mst));
    i2cr_partner u_far (.sys_clk(sys_clk), .cmd_start(c_st), .cmd_rstart(c_rs), .cmd_stop(c_sp),
        .scl_line(scl_l), .sda_line(sda_l));
    // ==========================================
    // pulse counters and hang guard
    always @(negedge sys_clk) begin
        n_st <= n_st + c_st;
        n_rs <= n_rs + c_rs;
        n_sp <= n_sp + c_sp;
        n_adv <= n_adv + adv;
        n_tk <= n_tk + tk;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ==========================================
    // bus tasks: sample at negedge, act at posedge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge sys_clk);
        awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1;
        do begin
            @(negedge sys_clk);
            ta = awv & awr; tw = wv & wr_; tb = bv; rs = bresp;
            @(posedge sys_clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!tb);
        brdy <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic tr, ta;
        @(posedge sys_clk);
        araddr <= a; arv <= 1'b1; rrdy <= 1'b1;
        do begin
            @(negedge sys_clk);
            ta = arv & arr; tr = rv; v = rdata; rs = rresp;
            @(posedge sys_clk);
            if (ta) arv <= 1'b0;
        end while (!tr);
        rrdy <= 1'b0;
    endtask
    task automatic ev(input logic [7:0] code);
        @(posedge sys_clk);
        esv <= 1'b1; estat <= code;
        @(posedge sys_clk);
        esv <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    // one-cycle engine event: bit 0 byte done, bit 1 nack, bit 2 address match
    task automatic pl(input logic [2:0] p);
        @(posedge sys_clk);
        epl <= p;
        @(posedge sys_clk);
        epl <= 3'h0;
        @(posedge sys_clk);
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(8'h08); chk(v, 32'h00000000);
        rd(8'h14); chk(v, 32'h000000F8);
        rd(8'h0C); chk(rs, 2'h2);
        wr(8'h08, 32'h00000020);
        repeat (30) @(posedge sys_clk);
        chk(n_st, 0);
        wr(8'h08, 32'h00000045);
        rd(8'h08); chk(v, 32'h00000045);
        chk(ack, 1'b1);
        wr(8'h04, 32'h00000001);
        rd(8'h04); chk(v, 32'h00000001);
        i = n_tk;
        repeat (160) @(posedge sys_clk);
        chk(n_tk - i, 10);
        ev(8'hF8);
        rd(8'h08); chk(v, 32'h00000045);
        ev(8'h08);
        rd(8'h08); chk(v, 32'h0000004D);
        chk(scl_oe, 1'b1);
        rd(8'h14); chk(v, 32'h00000008);
        wr(8'h08, 32'h0000004D);
        rd(8'h08); chk(v, 32'h0000004D);
        // settings complete before the flag is cleared
        wr(8'h08, 32'h00000045);
        rd(8'h08); chk(v, 32'h00000045);
        chk(n_adv, 1);
        chk(scl_oe, 1'b0);
        wr(8'h08, 32'h00000065);
        for (i = 0; i < 100 && mst !== 1'b1; i++) @(posedge sys_clk);
        chk(mst, 1'b1);
        chk(n_st, 1);
        rd(8'h08); chk(v, 32'h00000065);
        ev(8'h08);
        wr(8'h08, 32'h00000065);
        for (i = 0; i < 100 && n_rs == 0; i++) @(posedge sys_clk);
        chk(n_rs, 1);
        wr(8'h08, 32'h00000055);
        v = 32'hFFFFFFFF;
        for (i = 0; i < 20 && v[4] !== 1'b0; i++) rd(8'h08);
        chk(v, 32'h00000045);
        chk(n_sp, 1);
        pl(3'h4); chk(ssel, 1'b1);
        pl(3'h2); chk(ssel, 1'b0);
        pl(3'h4); wr(8'h08, 32'h00000041);
        pl(3'h1); chk(tidle, 1'b1);
        pl(3'h4); chk(ssel, 1'b0);
        wr(8'h08, 32'h00000045);
        pl(3'h4); chk(ssel, 1'b1);
        chk(tidle, 1'b0);
        ev(8'h00);
        rd(8'h08); chk(v, 32'h0000005D);
        repeat (30) @(posedge sys_clk);
        chk(n_sp, 1);
        final_report();
    end
endmodule // tb_i2c_control_register_logic
`default_nettype wire
